// ===== dv/host_master_model.sv
// Serial bus controller model that stands in for the baseband processor.
// Assumes an open-drain data line pulled up by the bench, clock_in at 100 MHz.
`timescale 1ns/1ns
`default_nettype none
module host_master_model (
  // Clock and resolved data line.
  input  wire logic clock_in,
  input  wire logic sda_in,
  // Driven bus pins.
  output logic      scl_out,
  output logic      sda_oe_out
);
  // ---------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------
  // The bus starts idle with both lines released high.
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Waits four clocks, then steps just off the edge before changing pins.
  task automatic quarter();
    repeat (4) @(posedge clock_in);
    #1;
  endtask : quarter

  // Sends one bit with SCL low, samples the line late in the high phase.
  task automatic bit_cycle(input logic b, output logic s);
    sda_oe_out = ~b;
    quarter();
    scl_out = 1'b1;
    quarter();
    s       = sda_in;
    scl_out = 1'b0;
  endtask : bit_cycle

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_oe_out = 1'b0;
    quarter();
    scl_out = 1'b1;
    quarter();
    sda_oe_out = 1'b1;
    quarter();
    scl_out = 1'b0;
  endtask : start_cond

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    quarter();
    scl_out = 1'b1;
    quarter();
    sda_oe_out = 1'b0;
    quarter();
  endtask : stop_cond

  // Sends a byte most significant bit first and returns the acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Receives a byte; nack high ends the read with a not-acknowledge.
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(nack, s);
  endtask : recv_byte
endmodule : host_master_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the dual-slot card control register bank.
// Assumes host_master_model as bus controller and a pulled-up data line.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import slot_ctrl_pkg::*;
  localparam logic [7:0] ID_VALUE = 8'hA5; // Arbitrary identification value.
  // Clock, reset and strap driven by the bench.
  logic            clock_in;
  logic            arst_n_in;
  logic            irq_level_in;
  // Bus wires; the data line is pulled up unless someone pulls it low.
  logic            scl;
  logic            host_oe;
  logic            dut_oe;
  logic            dut_sda;
  wire logic       sda_line;
  // Slot outputs of the bank.
  logic            one_en;
  logic            one_hi;
  logic [1:0]      one_st;
  logic            two_en;
  logic            two_hi;
  logic [1:0]      two_st;
  // Bookkeeping and expectations.
  int              fail_count;
  int              cmp_count;
  integer          seed;
  logic [6:0]      dev_addr;
  logic [7:0]      ctl_exp;
  logic [7:0]      got;
  logic            ack;

  // Open drain: either side pulls low, the pull-up wins otherwise.
  assign sda_line = (dut_oe ? dut_sda : 1'b1) & ~host_oe;

  slot_control_regs #(.HW_ID(ID_VALUE)) slot_control_regs_inst (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(dut_sda), .sda_oe_out(dut_oe), .irq_level_in(irq_level_in),
    .slot_one_supply_en_out(one_en), .slot_one_supply_hi_out(one_hi),
    .slot_one_state_out(one_st), .slot_two_supply_en_out(two_en),
    .slot_two_supply_hi_out(two_hi), .slot_two_state_out(two_st));

  host_master_model host_master_model_inst (
    .clock_in(clock_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));

  // ---------------------------------------------------------------
  // Clock, checks and bus tasks
  // ---------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  initial clock_in = 1'b0;
  always #5 clock_in = ~clock_in;

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Expected status byte: a down state with the regulator on reads as powered.
  function automatic logic [7:0] exp_status(input logic [7:0] c);
    logic [1:0] s1;
    logic [1:0] s2;
    s1 = (c[3:2] == 2'b00 && c[0]) ? 2'b10 : c[3:2];
    s2 = (c[7:6] == 2'b00 && c[4]) ? 2'b10 : c[7:6];
    return {s2, s1, 4'h0};
  endfunction : exp_status

  // Writes one data byte to a command; ok is high when all bytes were acked.
  task automatic reg_write(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    host_master_model_inst.start_cond();
    host_master_model_inst.send_byte({dev_addr, 1'b0}, a0);
    host_master_model_inst.send_byte(cmd, a1);
    host_master_model_inst.send_byte(data, a2);
    host_master_model_inst.stop_cond();
    ok = a0 & a1 & a2;
  endtask : reg_write

  // Selects a command, then reads one byte after a repeated start.
  task automatic reg_read(input logic [7:0] cmd, output logic [7:0] d);
    logic a;
    host_master_model_inst.start_cond();
    host_master_model_inst.send_byte({dev_addr, 1'b0}, a);
    host_master_model_inst.send_byte(cmd, a);
    host_master_model_inst.start_cond();
    host_master_model_inst.send_byte({dev_addr, 1'b1}, a);
    host_master_model_inst.recv_byte(1'b1, d);
    host_master_model_inst.stop_cond();
  endtask : reg_read

  // Compares control readback, status readback and the slot pins.
  task automatic check_all();
    reg_read(ADDR_CONTROL, got);
    check("control", ctl_exp, got);
    reg_read(ADDR_STATUS, got);
    check("status", exp_status(ctl_exp), got);
    check("pins", ctl_exp, {two_st, two_hi, two_en, one_st, one_hi, one_en});
  endtask : check_all

  // Holds reset for 8 cycles with the strap set, then lets the bank settle.
  task automatic do_reset(input logic strap);
    @(posedge clock_in);
    #1;
    arst_n_in    = 1'b0;
    irq_level_in = strap;
    dev_addr     = strap ? TARGET_ADDR_STRAP_HIGH : TARGET_ADDR_STRAP_LOW;
    repeat (8) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    repeat (8) @(posedge clock_in);
    #1;
  endtask : do_reset

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed         = 32'h937B;
    fail_count   = 0;
    cmp_count    = 0;
    arst_n_in    = 1'b0;
    irq_level_in = 1'b0;
    dev_addr     = TARGET_ADDR_STRAP_LOW;
    ctl_exp      = CONTROL_RESET;
    do_reset(1'b0);
    // Defaults straight out of reset.
    check_all();
    reg_read(ADDR_HW_ID, got);
    check("id", ID_VALUE, got);
    reg_read(ADDR_DRV_VER, got);
    check("version", 8'h00, got);
    reg_read(8'h02, got);
    check("unmapped", UNMAPPED_READ, got);
    // Every nibble code for each slot, the other slot random, the forbidden state included.
    for (int i = 0; i < 32; i++) begin
      ctl_exp = 8'($random(seed));
      if (i < 16) begin
        ctl_exp[3:0] = i[3:0];
      end else begin
        ctl_exp[7:4] = i[3:0];
      end
      reg_write(ADDR_CONTROL, ctl_exp, ack);
      check("write ack", 8'h01, {7'h00, ack});
      check_all();
    end
    // Writes aimed at read-only registers change nothing.
    reg_write(ADDR_HW_ID, 8'hFF, ack);
    reg_write(ADDR_DRV_VER, 8'hFF, ack);
    reg_write(ADDR_STATUS, 8'hFF, ack);
    reg_read(ADDR_HW_ID, got);
    check("id after write", ID_VALUE, got);
    reg_read(ADDR_DRV_VER, got);
    check("version after write", 8'h00, got);
    check_all();
    // The other strap address is not answered while the strap was low.
    dev_addr = TARGET_ADDR_STRAP_HIGH;
    reg_write(ADDR_CONTROL, 8'h00, ack);
    check("foreign ack", 8'h00, {7'h00, ack});
    dev_addr = TARGET_ADDR_STRAP_LOW;
    check_all();
    // A second reset with the strap high restores defaults and moves the address.
    do_reset(1'b1);
    ctl_exp = CONTROL_RESET;
    check_all();
    ctl_exp = 8'hE3;
    reg_write(ADDR_CONTROL, ctl_exp, ack);
    check("high address ack", 8'h01, {7'h00, ack});
    check_all();
    end_of_test();
  end

  // Watchdog: the sequence needs about 34500 cycles.
  initial begin
    repeat (90000) @(posedge clock_in);
    fail_count++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ===== include/slot_ctrl_pkg.sv
// Constants shared by the dual-slot card control register bank.
// Assumes nothing beyond a tool that reads SystemVerilog packages.
package slot_ctrl_pkg;

  // -----------------------------------------------------------------
  // Command bytes that select a register.
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_HW_ID   = 8'h00; // Hardware identification.
  localparam logic [7:0] ADDR_DRV_VER = 8'h01; // Driver version.
  localparam logic [7:0] ADDR_STATUS  = 8'h04; // Slot status.
  localparam logic [7:0] ADDR_CONTROL = 8'h08; // Slot control.

  // -----------------------------------------------------------------
  // Reset values.
  // -----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET        = 8'h00; // Control after reset.
  localparam logic [7:0] DRIVER_VERSION_RESET = 8'h00; // Version after reset.
  localparam logic [7:0] UNMAPPED_READ        = 8'h00; // Answer to other commands.

  // -----------------------------------------------------------------
  // Serial target addresses chosen by the strap level.
  // -----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR_STRAP_LOW  = 7'h3C; // Strap low.
  localparam logic [6:0] TARGET_ADDR_STRAP_HIGH = 7'h3D; // Strap high.

  // -----------------------------------------------------------------
  // Field layout: each slot owns one nibble of the control register.
  // -----------------------------------------------------------------
  localparam int SLOT_COUNT     = 2; // Number of card slots.
  localparam int CTL_SLOT_SPAN  = 4; // Control bits per slot.
  localparam int CTL_EN_POS     = 0; // Regulator enable inside a nibble.
  localparam int CTL_VSEL_POS   = 1; // Voltage select inside a nibble.
  localparam int CTL_STATE_POS  = 2; // State field inside a nibble.
  localparam int STAT_FIELD_POS = 4; // First status field in status byte.
  localparam int STAT_SPAN      = 2; // Status bits per slot.

  // Interface state and status codes.
  typedef enum logic [1:0] {
    ST_DOWN     = 2'b00, // Powered down, pull-downs on.
    ST_ISOLATED = 2'b01, // Isolated, pull-downs off.
    ST_POWERED  = 2'b10, // Powered, pull-downs on.
    ST_ACTIVE   = 2'b11  // Active, pull-downs off.
  } slot_state_t;

  // Serial engine states.
  typedef enum logic [2:0] {
    ENG_IDLE    = 3'b000, // Waiting for a start condition.
    ENG_RX      = 3'b001, // Shifting a byte in.
    ENG_RX_DONE = 3'b010, // Byte in, waiting for clock low.
    ENG_ACK     = 3'b011, // Acknowledge bit on the wire, own or the controller's.
    ENG_TX      = 3'b100, // Shifting a byte out.
    ENG_MACK    = 3'b101  // Controller acknowledge of a read byte.
  } eng_state_t;

endpackage : slot_ctrl_pkg

// ===== rtl/i2c_target_engine.sv
// Byte level two-wire serial target with acknowledge handling.
// Assumes bus pins already synchronous to clock_in and an external pull-up.
`timescale 1ns/1ns
`default_nettype none
module i2c_target_engine (
  // Clock and synchronised reset.
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Bus pins sampled as levels.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_out,
  // Register side.
  input  wire logic [6:0] dev_addr_in,
  input  wire logic [7:0] rd_data_in,
  output logic            wr_stb_out,
  output logic            wr_first_out,
  output logic [7:0]      wr_byte_out,
  output logic            rd_stb_out
);
  import slot_ctrl_pkg::*;

  // -----------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------
  eng_state_t state_q, state_d; // Engine state.
  logic [2:0] cnt_q, cnt_d;     // Bit counter.
  logic [7:0] shift_q, shift_d; // Shift register.
  logic       oe_q, oe_d;       // Pull data low while set.
  logic       first_q, first_d; // Next written byte is the command byte.
  logic       rw_q, rw_d;       // Transfer direction, set for reads.
  logic       aph_q, aph_d;     // Address byte phase.
  logic       scl_q, sda_q;     // Previous pin levels.
  logic       start, stop, rise, fall;

  // Bus conditions seen between two samples.
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop  = scl_in & scl_q & ~sda_q & sda_in;
  assign rise  = scl_in & ~scl_q;
  assign fall  = ~scl_in & scl_q;

  // -----------------------------------------------------------------
  // Next state; start and stop override any byte in progress.
  // -----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    shift_d    = shift_q;
    oe_d       = oe_q;
    first_d    = first_q;
    rw_d       = rw_q;
    aph_d      = aph_q;
    wr_stb_out = 1'b0;
    rd_stb_out = 1'b0;
    if (start) begin
      state_d = ENG_RX;
      cnt_d   = 3'h0;
      oe_d    = 1'b0;
      first_d = 1'b1;
      aph_d   = 1'b1;
      rw_d    = 1'b0;
    end else if (stop) begin
      state_d = ENG_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ENG_RX: begin
          // Data is taken on the rising clock edge.
          if (rise) begin
            shift_d = {shift_q[6:0], sda_in};
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              state_d = ENG_RX_DONE;
            end
          end
        end
        ENG_RX_DONE: begin
          if (fall) begin
            if (aph_q) begin
              // Acknowledge only our own address.
              if (shift_q[7:1] == dev_addr_in) begin
                oe_d    = 1'b1;
                rw_d    = shift_q[0];
                aph_d   = 1'b0;
                state_d = ENG_ACK;
              end else begin
                state_d = ENG_IDLE;
              end
            end else begin
              // Hand the byte over and acknowledge it.
              wr_stb_out = 1'b1;
              first_d    = 1'b0;
              oe_d       = 1'b1;
              state_d    = ENG_ACK;
            end
          end
        end
        ENG_ACK: begin
          if (fall) begin
            cnt_d = 3'h0;
            if (rw_q) begin
              // Load the read byte and drive its first bit.
              rd_stb_out = 1'b1;
              shift_d    = rd_data_in;
              oe_d       = ~rd_data_in[7];
              state_d    = ENG_TX;
            end else begin
              oe_d    = 1'b0;
              state_d = ENG_RX;
            end
          end
        end
        ENG_TX: begin
          if (fall) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              oe_d    = 1'b0;
              state_d = ENG_MACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = ~shift_q[6];
            end
          end
        end
        ENG_MACK: begin
          // A not-acknowledge ends the read.
          if (rise) begin
            state_d = sda_in ? ENG_IDLE : ENG_ACK;
          end
        end
        default: begin
          state_d = ENG_IDLE;
        end
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ENG_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      oe_q    <= 1'b0;
      first_q <= 1'b1;
      rw_q    <= 1'b0;
      aph_q   <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      oe_q    <= oe_d;
      first_q <= first_d;
      rw_q    <= rw_d;
      aph_q   <= aph_d;
      scl_q   <= scl_in;
      sda_q   <= sda_in;
    end
  end

  assign sda_oe_out   = oe_q;
  assign wr_first_out = first_q;
  assign wr_byte_out  = shift_q;

endmodule : i2c_target_engine
`default_nettype wire

// ===== rtl/slot_control_regs.sv
// Register bank of a dual-slot card multiplexer behind a serial target.
// Assumes bus pins synchronous to clock_in; pins are pulled up outside.
//
// What this block does
// - Command 00h reads fixed identification byte.
// - Command 01h reads driver version, zero.
// - Status 04h: slot one 5:4, two 7:6.
// - Status codes down, isolated, powered, active.
// - Status from state field and regulator bit.
// - Control at 08h read/write, resets zero.
// - Bits 0 and 4 switch slot regulators.
// - Bits 1 and 5 select 1.8/2.95 V.
// - Bits 3:2 and 7:6 set slot state.
// - State 10 is stored; host must not write it.
// - State and regulator bits stay independent.
// - Strap level at reset picks address 3Ch/3Dh.
// - Reset restores defaults, regulators off 1.8 V.
`timescale 1ns/1ns
`default_nettype none
module slot_control_regs #(
  parameter logic [7:0] HW_ID       = 8'h5A, // Arbitrary identification value.
  parameter logic [7:0] DRIVER_VERS = slot_ctrl_pkg::DRIVER_VERSION_RESET
) (
  // Clock and host reset.
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  // Serial bus pins and address strap.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       irq_level_in,
  // Slot one controls.
  output logic            slot_one_supply_en_out,
  output logic            slot_one_supply_hi_out,
  output logic [1:0]      slot_one_state_out,
  // Slot two controls.
  output logic            slot_two_supply_en_out,
  output logic            slot_two_supply_hi_out,
  output logic [1:0]      slot_two_state_out
);
  import slot_ctrl_pkg::*;

  // -----------------------------------------------------------------
  // Reset release through two flip-flops.
  // -----------------------------------------------------------------
  logic [1:0] rst_sync_q;   // Synchroniser chain.
  logic       rst_n;        // Released reset copy.

  // Host reset is asynchronous on entry and released on the clock.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // -----------------------------------------------------------------
  // Address strap, caught on the first edge after release.
  // -----------------------------------------------------------------
  logic       strap_done_q, strap_done_d; // Strap taken.
  logic       addr_sel_q, addr_sel_d;     // Strap level held.
  logic [6:0] dev_addr;                   // Own serial address.

  // The strap is sampled once; later pin activity is ignored.
  always_comb begin
    strap_done_d = 1'b1;
    addr_sel_d   = addr_sel_q;
    if (!strap_done_q) begin
      addr_sel_d = irq_level_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      addr_sel_q   <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      addr_sel_q   <= addr_sel_d;
    end
  end
  assign dev_addr = addr_sel_q ? TARGET_ADDR_STRAP_HIGH : TARGET_ADDR_STRAP_LOW;

  // -----------------------------------------------------------------
  // Serial engine; held in reset until the strap is known.
  // -----------------------------------------------------------------
  logic       wr_stb;   // Written byte strobe.
  logic       wr_first; // Byte is the command byte.
  logic [7:0] wr_byte;  // Written byte.
  logic       rd_stb;   // Read byte taken.
  logic [7:0] rd_data;  // Register selected for reading.

  i2c_target_engine u_engine (
    .clock_in     (clock_in),
    .rst_n_in     (strap_done_q),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_oe_out   (sda_oe_out),
    .dev_addr_in  (dev_addr),
    .rd_data_in   (rd_data),
    .wr_stb_out   (wr_stb),
    .wr_first_out (wr_first),
    .wr_byte_out  (wr_byte),
    .rd_stb_out   (rd_stb)
  );
  assign sda_out = 1'b0; // Open drain: only ever pulls low.

  // -----------------------------------------------------------------
  // Command pointer and control register.
  // -----------------------------------------------------------------
  logic [7:0] cmd_q, cmd_d;         // Selected register.
  logic [7:0] control_q, control_d; // Slot control.

  // The first byte after the address selects; later bytes write it.
  always_comb begin
    cmd_d     = cmd_q;
    control_d = control_q;
    if (wr_stb) begin
      if (wr_first) begin
        cmd_d = wr_byte;
      end else if (cmd_q == ADDR_CONTROL) begin
        control_d = wr_byte;
      end
      // Other commands are read-only; their writes fall away.
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q     <= ADDR_HW_ID;
      control_q <= CONTROL_RESET;
    end else begin
      cmd_q     <= cmd_d;
      control_q <= control_d;
    end
  end

  // -----------------------------------------------------------------
  // Per-slot decode of controls and status.
  // -----------------------------------------------------------------
  logic [SLOT_COUNT-1:0] supply_en;                 // Regulator on.
  logic [SLOT_COUNT-1:0] supply_hi;                 // High voltage chosen.
  logic [1:0]            slot_state [SLOT_COUNT];   // Written state.
  logic [1:0]            slot_status [SLOT_COUNT];  // Reported status.

  for (genvar s = 0; s < SLOT_COUNT; s++) begin : g_slot
    assign supply_en[s]  = control_q[s*CTL_SLOT_SPAN+CTL_EN_POS];
    assign supply_hi[s]  = control_q[s*CTL_SLOT_SPAN+CTL_VSEL_POS];
    assign slot_state[s] = control_q[s*CTL_SLOT_SPAN+CTL_STATE_POS +: 2];
    // A powered-down state with the regulator on reports as powered.
    assign slot_status[s] = (slot_state[s] == ST_DOWN && supply_en[s])
                            ? ST_POWERED : slot_state[s];
  end

  assign slot_one_supply_en_out = supply_en[0];
  assign slot_one_supply_hi_out = supply_hi[0];
  assign slot_one_state_out     = slot_state[0];
  assign slot_two_supply_en_out = supply_en[1];
  assign slot_two_supply_hi_out = supply_hi[1];
  assign slot_two_state_out     = slot_state[1];

  // -----------------------------------------------------------------
  // Read multiplexer.
  // -----------------------------------------------------------------
  always_comb begin
    case (cmd_q)
      ADDR_HW_ID:   rd_data = HW_ID;
      ADDR_DRV_VER: rd_data = DRIVER_VERS;
      ADDR_STATUS:  rd_data = {slot_status[1], slot_status[0], 4'h0};
      ADDR_CONTROL: rd_data = control_q;
      default:      rd_data = UNMAPPED_READ;
    endcase
  end

  // -----------------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  AST_ID_READ: assert property (cmd_q == ADDR_HW_ID |-> rd_data == HW_ID)
    else $error("identification read wrong");
  AST_VER_READ: assert property (cmd_q == ADDR_DRV_VER |-> rd_data == DRIVER_VERS)
    else $error("version read wrong");
  AST_STATUS_LOW: assert property (cmd_q == ADDR_STATUS |-> rd_data[3:0] == 4'h0)
    else $error("unused status bits not zero");
  AST_STATUS_POWERED: assert property (cmd_q == ADDR_STATUS && control_q[3:2] == 2'b00
    && control_q[0] |-> rd_data[5:4] == 2'b10)
    else $error("slot one status not powered");
  AST_STATUS_TWO: assert property (cmd_q == ADDR_STATUS && control_q[7:6] != 2'b00
    |-> rd_data[7:6] == control_q[7:6])
    else $error("slot two status mismatch");
  AST_CTRL_WRITE: assert property (wr_stb && !wr_first && cmd_q == ADDR_CONTROL
    |=> control_q == $past(wr_byte) && slot_one_supply_en_out == $past(wr_byte[0])
        && slot_two_supply_hi_out == $past(wr_byte[5]))
    else $error("control write not taken");
  AST_RO_IGNORED: assert property (wr_stb && cmd_q != ADDR_CONTROL |=> $stable(control_q))
    else $error("read-only write changed control");
  AST_ADDR_SEL: assert property ($rose(strap_done_q) |-> dev_addr ==
    ($past(irq_level_in) ? TARGET_ADDR_STRAP_HIGH : TARGET_ADDR_STRAP_LOW))
    else $error("target address wrong");
  AST_RESET_DEFAULT: assert property (disable iff (1'b0)
    $rose(rst_n) |-> control_q == 8'h00 && !slot_one_supply_en_out
    && !slot_two_supply_hi_out)
    else $error("control not default after reset");

  COV_CTRL_WRITE: cover property (wr_stb && !wr_first && cmd_q == ADDR_CONTROL);
  COV_STATUS_READ: cover property (rd_stb && cmd_q == ADDR_STATUS);
  COV_HIGH_STRAP: cover property (strap_done_q && addr_sel_q && rd_stb);
  COV_STATE_TEN: cover property (control_q[3:2] == 2'b10);

endmodule : slot_control_regs
`default_nettype wire
